//--- logic/idfw_top.sv
// Identify feature words: state, word assembly and read port
`timescale 1ns/1ps
`include "idfw_consts.svh"
module idfw_top
   import idfw_pkg::*;
#(
   parameter int          UDMA_MODES   = 7,
   parameter logic [2:0]  UDMA_MAX     = 3'h6,
   parameter logic [5:0]  SATA_SUP     = 6'h00,
   parameter logic        SEC_SUP      = 1'b1,
   parameter logic        WCACHE_SUP   = 1'b1,
   parameter logic        LOOKAHD_SUP  = 1'b1,
   parameter logic        APM_SUP      = 1'b0,
   parameter logic        ENH_ERASE    = 1'b0,
   parameter logic [15:0] ERASE_TIME   = 16'h0001
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   // Word read port
   input  wire logic        rd_en,
   input  wire idfw_index_t rd_index,
   output idfw_word_t       rd_data_r,
   output logic             rd_valid_r,
   output logic             rd_hit_r,
   // Feature enables from the command engine
   input  wire logic [5:0]  sata_en,
   input  wire logic        wcache_en,
   input  wire logic        lookahd_en,
   input  wire logic        apm_set,
   input  wire logic        apm_clr,
   // Transfer mode selection
   input  wire logic        sel_udma,
   input  wire logic        sel_mword,
   input  wire logic [2:0]  sel_mode,
   output logic             udma_active_r,
   output logic             mword_active_r,
   // Security state
   input  wire logic        pw_set,
   input  wire logic        pw_clear,
   input  wire logic        pw_level_max,
   input  wire logic        sec_lock,
   input  wire logic        sec_unlock,
   input  wire logic        sec_freeze,
   input  wire logic        sec_fail,
   input  wire logic        mpw_write,
   input  wire logic [15:0] mpw_rev,
   input  wire logic        unlock_or_erase,
   output logic             abort_cmd_r
);
   initial begin
      if (UDMA_MODES < 1 || UDMA_MODES > 7) $error("idfw_top: UDMA_MODES must be 1 to 7");
      if (32'(UDMA_MAX) >= UDMA_MODES) $error("idfw_top: UDMA_MAX beyond UDMA_MODES");
   end

   logic rst_s1_r;
   logic rst_s2_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   wire logic rst_n = rst_s2_r;

   // Enabled-feature state
   logic [5:0]     sata_en_r;
   logic           wcache_r;
   logic           lookahd_r;
   logic           apm_en_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sata_en_r <= 6'h00;
         wcache_r  <= 1'b0;
         lookahd_r <= 1'b0;
      end else begin
         sata_en_r <= sata_en & SATA_SUP;
         wcache_r  <= wcache_en & WCACHE_SUP;
         lookahd_r <= lookahd_en & LOOKAHD_SUP;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         apm_en_r <= 1'b0;
      end else if (apm_set && APM_SUP) begin
         apm_en_r <= 1'b1;
      end else if (apm_clr) begin
         apm_en_r <= 1'b0;
      end
   end

   // Transfer mode selection
   idfw_dma_kind_e dma_kind_r;
   logic [2:0]     udma_mode_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_kind_r  <= IDFW_DMA_NONE;
         udma_mode_r <= 3'h0;
      end else begin
         // A refused mode keeps the earlier selection
         // selecting one kind drops the other
         if (sel_udma && sel_mode <= UDMA_MAX) begin
            dma_kind_r  <= IDFW_DMA_ULTRA;
            udma_mode_r <= sel_mode;
         end else if (sel_mword) begin
            dma_kind_r  <= IDFW_DMA_MWORD;
         end
      end
   end

   // Security state
   logic        sec_en_r;
   logic        sec_max_r;
   logic        sec_locked_r;
   logic        sec_frozen_r;
   logic        sec_expired_r;
   logic [15:0] mpw_rev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_en_r  <= 1'b0;
         sec_max_r <= 1'b0;
      end else if (pw_set && SEC_SUP) begin
         sec_en_r  <= 1'b1;
         sec_max_r <= pw_level_max;
      end else if (pw_clear) begin
         sec_en_r  <= 1'b0;
         sec_max_r <= 1'b0;
      end
   end

   // Lock wins over unlock; dropping the password also unlocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_locked_r <= 1'b0;
      end else if (sec_lock && sec_en_r) begin
         sec_locked_r <= 1'b1;
      end else if (sec_unlock || !sec_en_r) begin
         sec_locked_r <= 1'b0;
      end
   end

   // Frozen stays set until a hardware reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_frozen_r <= 1'b0;
      end else if (sec_freeze && SEC_SUP) begin
         sec_frozen_r <= 1'b1;
      end
   end

   // expiry holds until a hardware reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_expired_r <= 1'b0;
      end else if (sec_fail && SEC_SUP) begin
         sec_expired_r <= 1'b1;
      end
   end

   // revision kept from the last master password change
   // Reads as unsupported until the first master password change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mpw_rev_r <= `IDFW_MPW_REV_NONE;
      end else if (mpw_write && SEC_SUP) begin
         mpw_rev_r <= mpw_rev;
      end
   end

   // Word assembly
   idfw_word_t udma_word;
   idfw_word_t sec_word;
   logic       abort_now;

   // capability is fixed on in this block
   idfw_udma_word #(
      .MODES (UDMA_MODES)
   ) u_udma (
      .max_mode      (UDMA_MAX),
      .udma_capable  (1'b1),
      .udma_selected (dma_kind_r == IDFW_DMA_ULTRA),
      .sel_mode      (udma_mode_r),
      .word          (udma_word)
   );

   idfw_sec_status u_sec (
      .sec_supported   (SEC_SUP),
      .sec_enabled     (sec_en_r),
      .sec_level_max   (sec_max_r),
      .sec_locked      (sec_locked_r),
      .sec_frozen      (sec_frozen_r),
      .sec_expired     (sec_expired_r),
      .enh_erase_sup   (ENH_ERASE),
      .unlock_or_erase (unlock_or_erase),
      .word            (sec_word),
      .abort_cmd       (abort_now)
   );

   idfw_word_t w_sata_sup;
   idfw_word_t w_sata_en;
   idfw_word_t w_sup_a;
   idfw_word_t w_sup_b;
   idfw_word_t w_en_a;
   idfw_word_t w_en_b;

   always_comb begin
      // support bits; reserved and bit 0 zero
      w_sata_sup = 16'h0000;
      w_sata_sup[`IDFW_SATA_MSB:`IDFW_SATA_LSB] = SATA_SUP;
      // enabled bits at the same positions
      w_sata_en = 16'h0000;
      w_sata_en[`IDFW_SATA_MSB:`IDFW_SATA_LSB] = sata_en_r;
      // fixed pattern of the supported word
      w_sup_a = `IDFW_CMD_A_FIXED;
      w_sup_a[`IDFW_CMD_A_SEC_BIT] = SEC_SUP;
      w_sup_a[`IDFW_CMD_A_WC_BIT]  = WCACHE_SUP;
      w_sup_a[`IDFW_CMD_A_LA_BIT]  = LOOKAHD_SUP;
      w_sup_b = `IDFW_VALID_SIG;
      w_sup_b[`IDFW_CMD_B_APM_BIT] = APM_SUP;
      w_en_a = `IDFW_CMD_A_FIXED;
      w_en_a[`IDFW_CMD_A_SEC_BIT] = sec_en_r;
      w_en_a[`IDFW_CMD_A_WC_BIT]  = wcache_r;
      w_en_a[`IDFW_CMD_A_LA_BIT]  = lookahd_r;
      w_en_b = 16'h0000;
      w_en_b[`IDFW_CMD_B_APM_BIT] = apm_en_r;
   end

   // Read port: one cycle latency, unknown index reads zero
   idfw_word_t rd_word;
   logic       rd_known;

   always_comb begin
      rd_known = 1'b1;
      // all other indices and bits zero
      rd_word  = 16'h0000;
      if (rd_index == `IDFW_W_SATA_SUP) begin
         rd_word = w_sata_sup;
      end else if (rd_index == `IDFW_W_SATA_EN) begin
         rd_word = w_sata_en;
      end else if (rd_index == `IDFW_W_CMD_SUP_A) begin
         rd_word = w_sup_a;
      end else if (rd_index == `IDFW_W_CMD_SUP_B) begin
         rd_word = w_sup_b;
      end else if (rd_index == `IDFW_W_CMD_SUP_C) begin
         // third word carries only the signature
         rd_word = `IDFW_VALID_SIG;
      end else if (rd_index == `IDFW_W_CMD_EN_A) begin
         rd_word = w_en_a;
      end else if (rd_index == `IDFW_W_CMD_EN_B) begin
         rd_word = w_en_b;
      end else if (rd_index == `IDFW_W_CMD_EN_C) begin
         rd_word = `IDFW_VALID_SIG;
      end else if (rd_index == `IDFW_W_UDMA) begin
         rd_word = udma_word;
      end else if (rd_index == `IDFW_W_ERASE_TIME) begin
         // value in units of two minutes
         rd_word = SEC_SUP ? ERASE_TIME : 16'h0000;
      end else if (rd_index == `IDFW_W_MPW_REV) begin
         rd_word = SEC_SUP ? mpw_rev_r : 16'h0000;
      end else if (rd_index == `IDFW_W_SEC_STATUS) begin
         rd_word = sec_word;
      end else begin
         rd_known = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r  <= 16'h0000;
         rd_valid_r <= 1'b0;
         rd_hit_r   <= 1'b0;
      end else begin
         // Data holds between reads, so a slow host may sample it late
         rd_valid_r <= rd_en;
         rd_hit_r   <= rd_en & rd_known;
         if (rd_en) begin
            rd_data_r <= rd_word;
         end
      end
   end

   // flags exclusive by construction of the kind state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         udma_active_r  <= 1'b0;
         mword_active_r <= 1'b0;
      end else begin
         udma_active_r  <= (dma_kind_r == IDFW_DMA_ULTRA);
         mword_active_r <= (dma_kind_r == IDFW_DMA_MWORD);
      end
   end

   // abort flag, one edge after the command is seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         abort_cmd_r <= 1'b0;
      end else begin
         abort_cmd_r <= abort_now;
      end
   end
endmodule : idfw_top

//--- logic/idfw_consts.svh
// Word indices, fixed bit patterns and field positions of the identify feature words
`ifndef IDFW_CONSTS_SVH
`define IDFW_CONSTS_SVH

`define IDFW_W_SATA_SUP      8'h4e
`define IDFW_W_SATA_EN       8'h4f
`define IDFW_W_CMD_SUP_A     8'h52
`define IDFW_W_CMD_SUP_B     8'h53
`define IDFW_W_CMD_SUP_C     8'h54
`define IDFW_W_CMD_EN_A      8'h55
`define IDFW_W_CMD_EN_B      8'h56
`define IDFW_W_CMD_EN_C      8'h57
`define IDFW_W_UDMA          8'h58
`define IDFW_W_ERASE_TIME    8'h59
`define IDFW_W_MPW_REV       8'h5c
`define IDFW_W_SEC_STATUS    8'h80

// Fixed ones: power management, write buffer, read buffer, no-operation
`define IDFW_CMD_A_FIXED     16'h7008
`define IDFW_CMD_A_SEC_BIT   1
`define IDFW_CMD_A_WC_BIT    5
`define IDFW_CMD_A_LA_BIT    6
`define IDFW_CMD_B_APM_BIT   3
// Validity signature: bit 14 one, bit 15 zero
`define IDFW_VALID_SIG       16'h4000

`define IDFW_SATA_LSB        1
`define IDFW_SATA_MSB        6
`define IDFW_UDMA_SEL_LSB    8

`define IDFW_SEC_SUP_BIT     0
`define IDFW_SEC_EN_BIT      1
`define IDFW_SEC_LOCK_BIT    2
`define IDFW_SEC_FROZEN_BIT  3
`define IDFW_SEC_EXP_BIT     4
`define IDFW_SEC_ENH_BIT     5
`define IDFW_SEC_LEVEL_BIT   8

`define IDFW_MPW_REV_NONE    16'hffff

`endif

//--- logic/idfw_pkg.sv
// Types shared by the identify feature word block
package idfw_pkg;
   typedef logic [15:0] idfw_word_t;
   typedef logic [7:0]  idfw_index_t;
   typedef enum logic [1:0] {
      IDFW_DMA_NONE  = 2'b00,
      IDFW_DMA_MWORD = 2'b01,
      IDFW_DMA_ULTRA = 2'b10
   } idfw_dma_kind_e;
endpackage : idfw_pkg

//--- logic/idfw_udma_word.sv
// Ultra DMA supported and selected word builder
`timescale 1ns/1ps
`include "idfw_consts.svh"
module idfw_udma_word
   import idfw_pkg::*;
#(
   parameter int MODES = 7
) (
   input  wire logic [2:0] max_mode,
   input  wire logic       udma_capable,
   input  wire logic       udma_selected,
   input  wire logic [2:0] sel_mode,
   output idfw_word_t      word
);
   initial begin
      if (MODES < 1 || MODES > 7) $error("idfw_udma_word: MODES must be 1 to 7");
   end

   logic [6:0] sup;
   logic [6:0] sel;

   always_comb begin
      sup = 7'h00;
      sel = 7'h00;
      for (int i = 0; i < MODES; i++) begin
         sup[i] = (3'(i) <= max_mode);
      end
      // one-hot selection, only within supported modes
      if (udma_selected && sel_mode <= max_mode && 32'(sel_mode) < MODES) begin
         sel[sel_mode] = 1'b1;
      end
      word = 16'h0000;
      if (udma_capable) begin
         word[`IDFW_UDMA_SEL_LSB +: 7] = sel;
         word[6:0]                     = sup;
      end
   end
endmodule : idfw_udma_word

//--- logic/idfw_sec_status.sv
// Security status word builder and unlock/erase abort decision
`timescale 1ns/1ps
`include "idfw_consts.svh"
module idfw_sec_status
   import idfw_pkg::*;
(
   input  wire logic sec_supported,
   input  wire logic sec_enabled,
   input  wire logic sec_level_max,
   input  wire logic sec_locked,
   input  wire logic sec_frozen,
   input  wire logic sec_expired,
   input  wire logic enh_erase_sup,
   input  wire logic unlock_or_erase,
   output idfw_word_t word,
   output logic      abort_cmd
);
   always_comb begin
      word = 16'h0000;
      if (sec_supported) begin
         word[`IDFW_SEC_SUP_BIT]    = 1'b1;
         word[`IDFW_SEC_EN_BIT]     = sec_enabled;
         word[`IDFW_SEC_LOCK_BIT]   = sec_locked;
         word[`IDFW_SEC_FROZEN_BIT] = sec_frozen;
         word[`IDFW_SEC_EXP_BIT]    = sec_expired;
         word[`IDFW_SEC_ENH_BIT]    = enh_erase_sup;
         word[`IDFW_SEC_LEVEL_BIT]  = sec_enabled & sec_level_max;
      end
   end

   // expired count aborts unlock and erase
   assign abort_cmd = unlock_or_erase & sec_supported & sec_expired;
endmodule : idfw_sec_status

//--- test/idfw_chk.sv
// Concurrent checks on the ports of the identify feature word block
`timescale 1ns/1ps
module idfw_chk
   import idfw_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        rd_en,
   input wire idfw_index_t rd_index,
   input wire idfw_word_t  rd_data_r,
   input wire logic        rd_valid_r,
   input wire logic        rd_hit_r,
   input wire logic        sec_fail,
   input wire logic        unlock_or_erase,
   input wire logic        udma_active_r,
   input wire logic        mword_active_r,
   input wire logic        abort_cmd_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A known word answered for a request taken one edge earlier
   sequence s_hit(idfw_index_t w);
      rd_valid_r && rd_hit_r && $past(rd_index) == w;
   endsequence
   sequence s_fail_cmd;
      sec_fail ##2 unlock_or_erase;
   endsequence
   a_read_answer: assert property (rd_en |=> rd_valid_r)
      else $error("read not answered");
   a_valid_cause: assert property (rd_valid_r |-> $past(rd_en))
      else $error("answer without request");
   a_cmd_fixed: assert property (s_hit(8'h52) or s_hit(8'h55) |->
      (rd_data_r & 16'h779d) == 16'h7008) else $error("fixed command bits wrong");
   a_valid_sig: assert property (s_hit(8'h53) or s_hit(8'h54) or s_hit(8'h57) |->
      rd_data_r[15:14] == 2'b01) else $error("signature wrong");
   a_sata_rsvd: assert property (s_hit(8'h4e) or s_hit(8'h4f) |->
      rd_data_r[15:7] == 9'h000 && !rd_data_r[0]) else $error("sata reserved set");
   a_cmd_b_zero: assert property (s_hit(8'h53) or s_hit(8'h56) |->
      (rd_data_r & 16'h0017) == 16'h0000) else $error("second word zeros set");
   a_udma_sel: assert property (s_hit(8'h58) |-> $onehot0(rd_data_r[14:8]) &&
      !rd_data_r[15] && !rd_data_r[7]) else $error("udma selection wrong");
   a_udma_cumul: assert property (s_hit(8'h58) |->
      ((rd_data_r[6:0] + 7'h01) & rd_data_r[6:0]) == 7'h00) else $error("udma gap");
   a_dma_excl: assert property (!(udma_active_r && mword_active_r))
      else $error("both dma kinds");
   a_abort_expired: assert property (s_fail_cmd |=> abort_cmd_r)
      else $error("no abort");
   a_abort_cause: assert property (abort_cmd_r |-> $past(unlock_or_erase))
      else $error("abort without command");
   a_level_bit: assert property (s_hit(8'h80) ##0 rd_data_r[8] |-> rd_data_r[1])
      else $error("level without enable");
endmodule : idfw_chk

bind idfw_top idfw_chk u_chk (.clk, .rstn, .rd_en, .rd_index, .rd_data_r, .rd_valid_r,
   .rd_hit_r, .sec_fail, .unlock_or_erase, .udma_active_r, .mword_active_r, .abort_cmd_r);

//--- test/idfw_host_model.sv
// Host controller model that fetches identify words one at a time
`timescale 1ns/1ps
module idfw_host_model
   import idfw_pkg::*;
(
   input  wire logic       clk,
   input  wire idfw_word_t rd_data_r,
   input  wire logic       rd_valid_r,
   input  wire logic       rd_hit_r,
   output logic            rd_en,
   output idfw_index_t     rd_index
);
   initial begin
      rd_en = 1'b0;
      rd_index = 8'h00;
   end
   task automatic fetch(input idfw_index_t idx, output idfw_word_t w, output logic hit,
                        output logic no_info, output logic late);
      int n;
      @(posedge clk);
      rd_en <= 1'b1;
      rd_index <= idx;
      @(posedge clk);
      rd_en <= 1'b0;
      // Index is meaningless once released, so it never idles at the old value
      rd_index <= ~idx;
      late = 1'b1;
      w = 16'h0000;
      hit = 1'b0;
      for (n = 0; n < 4 && late; n++) begin
         #1;
         if (rd_valid_r === 1'b1) begin
            w = rd_data_r;
            hit = rd_hit_r;
            late = 1'b0;
         end else @(posedge clk);
      end
      no_info = (w == 16'h0000) || (w == 16'hffff);
   endtask : fetch
endmodule : idfw_host_model

//--- test/tb.sv
// Self-checking bench for the identify feature word block
`timescale 1ns/1ps
module tb;
   import idfw_pkg::*;
   localparam logic [10:0] P_APM_SET = 11'h400, P_APM_CLR = 11'h200, P_UDMA = 11'h100,
      P_MWORD = 11'h080, P_PW_SET = 11'h040, P_PW_CLR = 11'h020, P_LOCK = 11'h010,
      P_UNLOCK = 11'h008, P_FREEZE = 11'h004, P_FAIL = 11'h002, P_MPW = 11'h001;
   // Rows: hit, index, word
   localparam logic [24:0] ROWS [13] = '{25'h1_4e_007e, 25'h1_4f_002a, 25'h1_52_706a,
      25'h1_53_4008, 25'h1_54_4000, 25'h1_55_7028, 25'h1_56_0000, 25'h1_57_4000,
      25'h1_58_007f, 25'h1_59_0005, 25'h1_5c_ffff, 25'h1_80_0021, 25'h0_50_0000};
   logic        clk, rstn, rd_en, rd_valid_r, rd_hit_r, hit, no_info, late;
   idfw_index_t rd_index;
   idfw_word_t  rd_data_r, w;
   logic [5:0]  sata_en;
   logic        wcache_en, lookahd_en, pw_level_max, unlock_or_erase;
   logic        udma_active_r, mword_active_r, abort_cmd_r;
   logic [2:0]  sel_mode;
   logic [15:0] mpw_rev;
   logic [10:0] pulses;
   int          n_errors, checked, i;

   idfw_top #(.SATA_SUP(6'h3f), .APM_SUP(1'b1), .ENH_ERASE(1'b1), .ERASE_TIME(16'h0005)) uut (
      .clk(clk), .rstn(rstn), .rd_en(rd_en), .rd_index(rd_index), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r), .rd_hit_r(rd_hit_r), .sata_en(sata_en),
      .wcache_en(wcache_en), .lookahd_en(lookahd_en), .apm_set(pulses[10]),
      .apm_clr(pulses[9]), .sel_udma(pulses[8]), .sel_mword(pulses[7]),
      .sel_mode(sel_mode), .udma_active_r(udma_active_r), .mword_active_r(mword_active_r),
      .pw_set(pulses[6]), .pw_clear(pulses[5]), .pw_level_max(pw_level_max),
      .sec_lock(pulses[4]), .sec_unlock(pulses[3]), .sec_freeze(pulses[2]),
      .sec_fail(pulses[1]), .mpw_write(pulses[0]), .mpw_rev(mpw_rev),
      .unlock_or_erase(unlock_or_erase), .abort_cmd_r(abort_cmd_r));
   idfw_host_model host (.clk(clk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .rd_hit_r(rd_hit_r), .rd_en(rd_en), .rd_index(rd_index));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk_word(input string what, input idfw_word_t exp, input idfw_word_t got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic rd(input idfw_index_t idx, input idfw_word_t exp);
      host.fetch(idx, w, hit, no_info, late);
      if (late) begin
         n_errors++;
         final_report();
      end
      chk_word($sformatf("word %h", idx), exp, w);
   endtask : rd
   task automatic pulse(input logic [10:0] p);
      @(posedge clk);
      pulses <= p;
      @(posedge clk);
      pulses <= 11'h000;
   endtask : pulse

   initial begin
      rstn = 1'b0;
      sata_en = 6'h15;
      wcache_en = 1'b1;
      lookahd_en = 1'b0;
      pw_level_max = 1'b1;
      unlock_or_erase = 1'b0;
      sel_mode = 3'h0;
      mpw_rev = 16'h1234;
      pulses = 11'h000;
      n_errors = 0;
      checked = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 13; i++) begin
         rd(ROWS[i][23:16], ROWS[i][15:0]);
         chk_bit("hit", ROWS[i][24], hit);
         if (ROWS[i][23:16] inside {8'h52, 8'h53, 8'h54, 8'h55, 8'h57})
            chk_bit("no_info", 1'b0, no_info);
      end
      pulse(P_APM_SET);
      rd(8'h56, 16'h0008);
      pulse(P_APM_CLR);
      rd(8'h56, 16'h0000);
      pulse(P_PW_SET | P_MPW);
      rd(8'h55, 16'h702a);
      rd(8'h80, 16'h0123);
      rd(8'h5c, 16'h1234);
      pulse(P_LOCK);
      rd(8'h80, 16'h0127);
      pulse(P_UNLOCK);
      rd(8'h80, 16'h0123);
      pulse(P_PW_CLR);
      rd(8'h80, 16'h0021);
      @(posedge clk);
      pw_level_max <= 1'b0;
      pulse(P_PW_SET);
      rd(8'h80, 16'h0023);
      pulse(P_FREEZE);
      rd(8'h80, 16'h002b);
      for (i = 0; i < 7; i++) begin
         @(posedge clk);
         sel_mode <= i[2:0];
         pulse(P_UDMA);
         rd(8'h58, 16'h007f | (16'h0100 << i));
         chk_bit("udma_active", 1'b1, udma_active_r);
      end
      pulse(P_MWORD);
      rd(8'h58, 16'h007f);
      chk_bit("mword_active", 1'b1, mword_active_r);
      chk_bit("udma_active", 1'b0, udma_active_r);
      @(posedge clk);
      sel_mode <= 3'h7;
      pulse(P_UDMA);
      rd(8'h58, 16'h007f);
      @(posedge clk);
      unlock_or_erase <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk_bit("abort", 1'b0, abort_cmd_r);
      pulse(P_FAIL);
      repeat (2) @(posedge clk);
      #1 chk_bit("abort", 1'b1, abort_cmd_r);
      rd(8'h80, 16'h003b);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk_bit("abort", 1'b0, abort_cmd_r);
      rd(8'h80, 16'h0021);
      rd(8'h5c, 16'hffff);
      rd(8'h58, 16'h007f);
      @(posedge clk);
      sata_en    <= 6'h2a;
      wcache_en  <= 1'b0;
      lookahd_en <= 1'b1;
      pulse(P_APM_SET | P_APM_CLR | P_PW_SET | P_PW_CLR);
      rd(8'h4f, 16'h0054);
      rd(8'h56, 16'h0008);
      rd(8'h55, 16'h704a);
      rd(8'h80, 16'h0023);
      final_report();
   end
endmodule : tb
